// ---- test/cwr_pin_model.sv ----
// Far-side model: reset pin with pull-up and a crystal oscillator
`default_nettype none
module cwr_pin_model (
	input wire logic ref_clk, // System clock
	input wire logic hold_low, // Drive the pin low
	input wire logic osc_run, // Crystal is oscillating
	output logic ext_reset_pin, // Pin level
	output logic osc_tick // Oscillator pulse, every other cycle
);
	timeunit 1ns;
	timeprecision 1ns;
	logic half_r = 1'b0;
	// A released pin rises to the pull-up level
	assign ext_reset_pin = hold_low ? 1'b0 : 1'b1;
	assign osc_tick = osc_run & half_r;
	always @(posedge ref_clk) begin
		half_r <= ~half_r;
	end
endmodule
`default_nettype wire

// ---- test/cwr_reset_ctrl_tb.sv ----
// Self-checking bench for the configuration word and reset controller
`default_nettype none
module cwr_reset_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned PU = 50;
	localparam int unsigned OT = 8;
	localparam int unsigned GL = 3;
	logic ref_clk = 1'b0, rst_n = 1'b0, vdd_ok = 1'b1, brown_out_low = 1'b0, wdt_timeout = 1'b0;
	logic int_wake = 1'b0, sleep_req = 1'b0, por_flag_set = 1'b0, prog_mode = 1'b1, prog_wr = 1'b0;
	logic prog_rd = 1'b0, hold_low = 1'b0, osc_run = 1'b1, low_seen = 1'b0;
	logic [13:0] prog_addr = 14'h0000;
	logic [15:0] prog_wdata = 16'h0000;
	logic [15:0] rv;
	wire logic ext_reset_pin, osc_tick, erase_pulse, chip_reset_n, core_run, power_on_flag, wake_pulse;
	wire logic sleeping, clkout_en, osc_pins_crystal, int_osc_8mhz, code_protect_en, watchdog_en;
	wire logic brown_out_en, pin_pullup_en, pin_digital_in, int_osc_stop;
	wire logic [15:0] prog_rdata;
	wire logic [2:0] reset_kind, osc_mode;
	int errors = 0, checks = 0, n = 0;
	cwr_reset_ctrl #(.POWER_UP_CYCLES(PU), .OSC_START_TICKS(OT), .GLITCH_CYCLES(GL)) dut_u (
		.ref_clk, .rst_n, .vdd_ok, .brown_out_low, .wdt_timeout, .int_wake, .sleep_req, .ext_reset_pin,
		.osc_tick, .por_flag_set, .prog_mode, .prog_addr, .prog_wr, .prog_rd, .prog_wdata, .prog_rdata,
		.erase_pulse, .chip_reset_n, .core_run, .reset_kind, .power_on_flag, .wake_pulse, .sleeping,
		.osc_mode, .clkout_en, .osc_pins_crystal, .int_osc_8mhz, .code_protect_en, .watchdog_en,
		.brown_out_en, .pin_pullup_en, .pin_digital_in, .int_osc_stop);
	cwr_pin_model pin_u (.ref_clk, .hold_low, .osc_run, .ext_reset_pin, .osc_tick);
	always #50 ref_clk = ~ref_clk;
	always @(negedge ref_clk) if (chip_reset_n !== 1'b1) low_seen = 1'b1;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask
	task automatic wr(input logic [13:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		prog_addr <= a;
		prog_wdata <= d;
		prog_wr <= 1'b1;
		@(posedge ref_clk);
		prog_wr <= 1'b0;
		@(negedge ref_clk);
	endtask
	task automatic rd(input logic [13:0] a);
		@(posedge ref_clk);
		prog_addr <= a;
		prog_rd <= 1'b1;
		@(posedge ref_clk);
		prog_rd <= 1'b0;
		@(negedge ref_clk);
		rv = prog_rdata;
	endtask
	// Count negedges until the internal reset reaches the given level
	task automatic wait_rst(input logic lvl);
		n = 0;
		while (chip_reset_n !== lvl && n < 2000) begin
			@(negedge ref_clk);
			n++;
		end
		check(chip_reset_n, lvl);
	endtask
	task automatic t_defaults;
		rd(cwr_pkg::CFG_ADDR);
		check(rv, cwr_pkg::CFG_ERASED);
		check({osc_mode, clkout_en, osc_pins_crystal}, 5'h1e);
		check({int_osc_8mhz, code_protect_en, watchdog_en, brown_out_en, pin_pullup_en}, 5'h17);
		check(power_on_flag, 1'b0);
		check(chip_reset_n, 1'b1);
		$display("test defaults done");
	endtask
	task automatic t_decode;
		for (int m = 0; m < 8; m++) begin
			wr(cwr_pkg::CFG_ADDR, 16'h03a8 | 16'(m));
			rd(cwr_pkg::CFG_ADDR);
			check(rv, 16'hffa8 | 16'(m));
			check({osc_mode, clkout_en, osc_pins_crystal}, {3'(m), m == 7 || m == 5, m < 3});
			check({int_osc_8mhz, code_protect_en, watchdog_en}, 3'h7);
		end
		wr(cwr_pkg::CFG_ADDR, 16'h0070);
		check({int_osc_8mhz, code_protect_en, watchdog_en, brown_out_en}, 4'h0);
		wr(14'h2006, 16'h0000);
		rd(14'h2006);
		check(rv, 16'h0000);
		@(posedge ref_clk);
		prog_mode <= 1'b0;
		wr(cwr_pkg::CFG_ADDR, 16'h0000);
		@(posedge ref_clk);
		prog_mode <= 1'b1;
		rd(cwr_pkg::CFG_ADDR);
		check(rv, 16'hfc70);
		$display("test decode done");
	endtask
	task automatic t_erase_bor;
		wr(cwr_pkg::CFG_ADDR, 16'hffbf);
		check({erase_pulse, code_protect_en}, 2'h1);
		wr(cwr_pkg::CFG_ADDR, 16'hffff);
		check(erase_pulse, 1'b1);
		@(negedge ref_clk);
		check(erase_pulse, 1'b0);
		for (int s = 0; s < 4; s++) begin
			wr(cwr_pkg::CFG_ADDR, {6'h3f, 2'(s), 8'hff});
			check(brown_out_en, s > 1);
		end
		$display("test erase and brown-out select done");
	endtask
	task automatic t_power_up;
		wr(cwr_pkg::CFG_ADDR, 16'hffe9);
		@(posedge ref_clk);
		por_flag_set <= 1'b1;
		@(posedge ref_clk);
		por_flag_set <= 1'b0;
		vdd_ok <= 1'b0;
		cyc(3);
		@(negedge ref_clk);
		check({chip_reset_n, core_run, power_on_flag}, 3'h0);
		check(reset_kind, cwr_pkg::KIND_POWER_ON);
		check(osc_mode, 3'h1);
		@(posedge ref_clk);
		vdd_ok <= 1'b1;
		wait_rst(1'b1);
		check(n >= PU + 2 * OT - 2 && n < PU + 2 * OT + 12, 1'b1);
		check(core_run, 1'b1);
		wr(cwr_pkg::CFG_ADDR, 16'hfff9);
		@(posedge ref_clk);
		osc_run <= 1'b0;
		vdd_ok <= 1'b0;
		cyc(3);
		vdd_ok <= 1'b1;
		cyc(100);
		@(negedge ref_clk);
		check(chip_reset_n, 1'b0);
		@(posedge ref_clk);
		osc_run <= 1'b1;
		wait_rst(1'b1);
		check(n <= 2 * OT + 4, 1'b1);
		$display("test power-up done");
	endtask
	task automatic t_brown;
		for (int k = 0; k < 2; k++) begin
			wr(cwr_pkg::CFG_ADDR, k == 0 ? 16'hffef : 16'hffff);
			@(posedge ref_clk);
			brown_out_low <= 1'b1;
			cyc(3);
			brown_out_low <= 1'b0;
			wait_rst(1'b1);
			check(k == 0 ? n >= PU : n < 5, 1'b1);
			check(reset_kind, cwr_pkg::KIND_BROWN_OUT);
		end
		$display("test brown-out done");
	endtask
	task automatic t_ext;
		@(posedge ref_clk);
		low_seen = 1'b0;
		hold_low <= 1'b1;
		cyc(GL - 1);
		hold_low <= 1'b0;
		cyc(10);
		check(low_seen, 1'b0);
		hold_low <= 1'b1;
		cyc(GL + 3);
		@(negedge ref_clk);
		check({chip_reset_n, int_osc_stop}, 2'h1);
		@(posedge ref_clk);
		hold_low <= 1'b0;
		wait_rst(1'b1);
		check(n <= GL + 3, 1'b1);
		check(reset_kind, cwr_pkg::KIND_EXT_RUN);
		wr(cwr_pkg::CFG_ADDR, 16'hffdf);
		@(posedge ref_clk);
		hold_low <= 1'b1;
		cyc(GL + 3);
		@(negedge ref_clk);
		check({chip_reset_n, pin_digital_in, pin_pullup_en}, 3'h4);
		@(posedge ref_clk);
		hold_low <= 1'b0;
		cyc(2);
		@(negedge ref_clk);
		check(pin_digital_in, 1'b1);
		$display("test external pin done");
	endtask
	task automatic t_wdt;
		@(posedge ref_clk);
		por_flag_set <= 1'b1;
		@(posedge ref_clk);
		por_flag_set <= 1'b0;
		wdt_timeout <= 1'b1;
		@(posedge ref_clk);
		wdt_timeout <= 1'b0;
		wait_rst(1'b0);
		check(n < 4, 1'b1);
		wait_rst(1'b1);
		check(n < 4, 1'b1);
		check(reset_kind, cwr_pkg::KIND_WATCHDOG_RUN);
		check(power_on_flag, 1'b1);
		$display("test watchdog done");
	endtask
	task automatic go_sleep;
		@(posedge ref_clk);
		sleep_req <= 1'b1;
		@(posedge ref_clk);
		sleep_req <= 1'b0;
		@(negedge ref_clk);
		check({sleeping, brown_out_en}, 2'h2);
		@(posedge ref_clk);
		low_seen = 1'b0;
	endtask
	task automatic wait_wake;
		n = 0;
		while (wake_pulse !== 1'b1 && n < 20) begin
			@(negedge ref_clk);
			n++;
		end
		check(wake_pulse, 1'b1);
	endtask
	task automatic t_sleep;
		wr(cwr_pkg::CFG_ADDR, 16'hfeff);
		go_sleep();
		wdt_timeout <= 1'b1;
		@(posedge ref_clk);
		wdt_timeout <= 1'b0;
		wait_wake();
		check({low_seen, sleeping}, 2'h0);
		check(reset_kind, cwr_pkg::KIND_WATCHDOG_SLEEP);
		go_sleep();
		int_wake <= 1'b1;
		@(posedge ref_clk);
		int_wake <= 1'b0;
		wait_wake();
		check(reset_kind, cwr_pkg::KIND_WATCHDOG_SLEEP);
		go_sleep();
		hold_low <= 1'b1;
		cyc(GL + 3);
		hold_low <= 1'b0;
		wait_rst(1'b1);
		check(reset_kind, cwr_pkg::KIND_EXT_SLEEP);
		$display("test sleep done");
	endtask
	initial begin
		#3000000;
		errors++;
		print_verdict();
	end
	initial begin
		cyc(20);
		rst_n <= 1'b1;
		cyc(3);
		@(negedge ref_clk);
		t_defaults();
		t_decode();
		t_erase_bor();
		t_power_up();
		t_brown();
		t_ext();
		t_wdt();
		t_sleep();
		print_verdict();
	end
endmodule
`default_nettype wire

// ---- verilog/cwr_glitch_filter.sv ----
// Noise filter: the level follows the input only after it holds steady
`default_nettype none
module cwr_glitch_filter #(
	parameter int unsigned LEN = 20
) (
	input wire logic ref_clk, // System clock
	input wire logic rst_n, // Synchronous reset
	input wire logic raw, // Unfiltered level
	output logic level // Filtered level
);
	localparam int W = $clog2(LEN + 1);
	localparam logic [W-1:0] LAST = W'(LEN - 1);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic lvl;
	} cwr_filt_t;
	cwr_filt_t s, n;
	always_comb begin
		n = s;
		if (raw == s.lvl) begin
			n.cnt = '0;
		end else if (s.cnt == LAST) begin
			n.cnt = '0;
			n.lvl = raw;
		end else begin
			n.cnt = s.cnt + W'(1);
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			s <= '0;
		else
			s <= n;
	end
	assign level = s.lvl;
	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	filter_len_a: assert property ($changed(s.lvl) |-> $past(s.cnt) == LAST)
		else $error("Filtered level changed before the input held long enough");
endmodule
`default_nettype wire

// ---- verilog/cwr_pkg.sv ----
// Shared constants and types for the configuration word and reset controller
`default_nettype none
package cwr_pkg;
	localparam logic [13:0] CFG_ADDR = 14'h2007;
	localparam logic [15:0] CFG_ERASED = 16'hffff;
	localparam logic [15:0] CFG_UNIMPL_MASK = 16'hfc00;
	localparam int BROWN_OUT_SEL_HI = 9;
	localparam int BROWN_OUT_SEL_LO = 8;
	localparam int FREQ_SEL_BIT = 7;
	localparam int CODE_PROTECT_BIT = 6;
	localparam int PIN_FN_BIT = 5;
	localparam int POWER_UP_DIS_BIT = 4;
	localparam int WATCHDOG_EN_BIT = 3;
	localparam int OSC_SEL_HI = 2;
	localparam int OSC_SEL_LO = 0;
	localparam logic [1:0] BROWN_OUT_ALWAYS = 2'h3;
	localparam logic [1:0] BROWN_OUT_RUN_ONLY = 2'h2;
	localparam int CLK_PERIOD_NS = 100;
	localparam int POWER_UP_TIME_MS = 64;
	localparam int POWER_UP_CYCLES = POWER_UP_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int OSC_START_TICKS = 1024;
	localparam int GLITCH_TIME_NS = 2000;
	localparam int GLITCH_CYCLES = (GLITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [2:0] {
		LOW_POWER_CRYSTAL_MODE = 3'h0,
		STANDARD_CRYSTAL_MODE = 3'h1,
		HIGH_SPEED_CRYSTAL_MODE = 3'h2,
		EXTERNAL_CLOCK_MODE = 3'h3,
		INTERNAL_OSC_IO_MODE = 3'h4,
		INTERNAL_OSC_CLOCKOUT_MODE = 3'h5,
		RC_OSC_IO_MODE = 3'h6,
		RC_CLOCKOUT_MODE = 3'h7
	} cwr_osc_mode_t;
	typedef enum logic [2:0] {
		ST_HOLD = 3'h0,
		ST_POWER_UP = 3'h1,
		ST_OSC_START = 3'h3,
		ST_RUN = 3'h2,
		ST_SLEEP = 3'h6
	} cwr_state_t;
	typedef enum logic [2:0] {
		KIND_POWER_ON = 3'h0,
		KIND_WATCHDOG_RUN = 3'h1,
		KIND_WATCHDOG_SLEEP = 3'h2,
		KIND_EXT_RUN = 3'h3,
		KIND_EXT_SLEEP = 3'h4,
		KIND_BROWN_OUT = 3'h5
	} cwr_kind_t;
endpackage
`default_nettype wire

// ---- verilog/cwr_reset_ctrl.sv ----
// Configuration word decode and internal reset sequencer
`default_nettype none
module cwr_reset_ctrl #(
	parameter int unsigned POWER_UP_CYCLES = cwr_pkg::POWER_UP_CYCLES,
	parameter int unsigned OSC_START_TICKS = cwr_pkg::OSC_START_TICKS,
	parameter int unsigned GLITCH_CYCLES = cwr_pkg::GLITCH_CYCLES
) (
	input wire logic ref_clk, // 10 MHz clock
	input wire logic rst_n, // Synchronous power-on reset
	input wire logic vdd_ok, // Supply adequate
	input wire logic brown_out_low, // Supply below brown-out threshold
	input wire logic wdt_timeout, // Watchdog expiry pulse
	input wire logic int_wake, // Interrupt wake request
	input wire logic sleep_req, // Enter sleep pulse
	input wire logic ext_reset_pin, // Reset pin level, low asserts
	input wire logic osc_tick, // One pulse per oscillator cycle
	input wire logic por_flag_set, // Software writes 1 to power-on flag
	input wire logic prog_mode, // Programming port active
	input wire logic [13:0] prog_addr, // Programming address
	input wire logic prog_wr, // Programming write strobe
	input wire logic prog_rd, // Programming read strobe
	input wire logic [15:0] prog_wdata, // Programming write data
	output logic [15:0] prog_rdata, // Programming read data
	output logic erase_pulse, // Erase all program memory
	output logic chip_reset_n, // Combined internal reset
	output logic core_run, // Core may execute
	output logic [2:0] reset_kind, // Last reset cause
	output logic power_on_flag, // Power-on status flag
	output logic wake_pulse, // Left sleep
	output logic sleeping, // In sleep
	output logic [2:0] osc_mode, // Oscillator select
	output logic clkout_en, // Clock-out on oscillator pin
	output logic osc_pins_crystal, // Both oscillator pins for crystal
	output logic int_osc_8mhz, // Internal oscillator at 8 MHz
	output logic code_protect_en, // Program memory protected
	output logic watchdog_en, // Watchdog enabled
	output logic brown_out_en, // Brown-out detect enabled
	output logic pin_pullup_en, // Weak pull-up on reset pin
	output logic pin_digital_in, // Pin value as digital input
	output logic int_osc_stop // Stop internal clock oscillator
);
	typedef struct packed {
		cwr_pkg::cwr_state_t st;
		cwr_pkg::cwr_kind_t kind;
		logic por_flag;
		logic [15:0] cfg;
		logic [15:0] rdata;
		logic wdt_rst;
		logic wake;
		logic erase;
		logic ext_prev;
		logic from_wake;
		logic pin_din;
	} cwr_ctrl_t;
	cwr_ctrl_t s, n;
	logic pin_low_filt;
	logic ext_active;
	logic pu_done;
	logic os_done;
	logic bor_act;
	logic crystal;
	logic cfg_hit;

	function automatic logic is_crystal(input logic [2:0] m);
		return m == cwr_pkg::LOW_POWER_CRYSTAL_MODE || m == cwr_pkg::STANDARD_CRYSTAL_MODE
			|| m == cwr_pkg::HIGH_SPEED_CRYSTAL_MODE;
	endfunction

	function automatic logic brown_out_on(input logic [1:0] sel, input logic slp);
		return sel == cwr_pkg::BROWN_OUT_ALWAYS || (sel == cwr_pkg::BROWN_OUT_RUN_ONLY && !slp);
	endfunction

	// Pin is sensed only; no watchdog path drives it
	cwr_glitch_filter #(.LEN(GLITCH_CYCLES)) u_pin_filt (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.raw(!ext_reset_pin),
		.level(pin_low_filt)
	);
	cwr_timeout_counter #(.LIMIT(POWER_UP_CYCLES)) u_power_up (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.run(s.st == cwr_pkg::ST_POWER_UP),
		.tick(1'b1),
		.done(pu_done)
	);
	cwr_timeout_counter #(.LIMIT(OSC_START_TICKS)) u_osc_start (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.run(s.st == cwr_pkg::ST_OSC_START),
		.tick(osc_tick),
		.done(os_done)
	);

	assign ext_active = s.cfg[cwr_pkg::PIN_FN_BIT] && pin_low_filt;
	assign crystal = is_crystal(s.cfg[cwr_pkg::OSC_SEL_HI:cwr_pkg::OSC_SEL_LO]);
	assign bor_act = brown_out_low
		&& brown_out_on(s.cfg[cwr_pkg::BROWN_OUT_SEL_HI:cwr_pkg::BROWN_OUT_SEL_LO], s.st == cwr_pkg::ST_SLEEP);
	assign cfg_hit = prog_mode && prog_addr == cwr_pkg::CFG_ADDR;

	always_comb begin
		n = s;
		n.wdt_rst = 1'b0;
		n.wake = 1'b0;
		n.erase = 1'b0;
		n.ext_prev = ext_active;
		n.pin_din = s.cfg[cwr_pkg::PIN_FN_BIT] ? 1'b0 : ext_reset_pin;
		if (por_flag_set)
			n.por_flag = 1'b1;
		// Config word survives every internal reset
		if (cfg_hit && prog_wr) begin
			n.cfg = prog_wdata | cwr_pkg::CFG_UNIMPL_MASK;
			n.erase = !s.cfg[cwr_pkg::CODE_PROTECT_BIT] && prog_wdata[cwr_pkg::CODE_PROTECT_BIT];
		end
		if (prog_mode && prog_rd)
			n.rdata = cfg_hit ? s.cfg : 16'h0000;
		unique case (s.st)
			cwr_pkg::ST_HOLD: begin
				if (vdd_ok && !bor_act) begin
					n.from_wake = 1'b0;
					if (!s.cfg[cwr_pkg::POWER_UP_DIS_BIT])
						n.st = cwr_pkg::ST_POWER_UP;
					else if (crystal)
						n.st = cwr_pkg::ST_OSC_START;
					else
						n.st = cwr_pkg::ST_RUN;
				end
			end
			cwr_pkg::ST_POWER_UP: begin
				if (bor_act) begin
					n.st = cwr_pkg::ST_HOLD;
					n.kind = cwr_pkg::KIND_BROWN_OUT;
				end else if (pu_done) begin
					n.st = crystal ? cwr_pkg::ST_OSC_START : cwr_pkg::ST_RUN;
				end
			end
			cwr_pkg::ST_OSC_START: begin
				if (bor_act) begin
					n.st = cwr_pkg::ST_HOLD;
					n.kind = cwr_pkg::KIND_BROWN_OUT;
				end else if (os_done) begin
					n.st = cwr_pkg::ST_RUN;
					n.from_wake = 1'b0;
				end
			end
			cwr_pkg::ST_RUN: begin
				if (bor_act) begin
					n.st = cwr_pkg::ST_HOLD;
					n.kind = cwr_pkg::KIND_BROWN_OUT;
				end else if (wdt_timeout) begin
					n.wdt_rst = 1'b1;
					n.kind = cwr_pkg::KIND_WATCHDOG_RUN;
				end else if (ext_active && !s.ext_prev) begin
					n.kind = cwr_pkg::KIND_EXT_RUN;
				end else if (sleep_req && !ext_active) begin
					n.st = cwr_pkg::ST_SLEEP;
				end
			end
			cwr_pkg::ST_SLEEP: begin
				if (bor_act) begin
					n.st = cwr_pkg::ST_HOLD;
					n.kind = cwr_pkg::KIND_BROWN_OUT;
				end else if (ext_active) begin
					n.st = cwr_pkg::ST_RUN;
					n.kind = cwr_pkg::KIND_EXT_SLEEP;
					n.wake = 1'b1;
				end else if (wdt_timeout || int_wake) begin
					// Wake resumes; no register reset
					n.wake = 1'b1;
					n.from_wake = crystal;
					n.st = crystal ? cwr_pkg::ST_OSC_START : cwr_pkg::ST_RUN;
					if (wdt_timeout)
						n.kind = cwr_pkg::KIND_WATCHDOG_SLEEP;
				end
			end
			default: n.st = cwr_pkg::ST_HOLD;
		endcase
		if (!vdd_ok) begin
			n.st = cwr_pkg::ST_HOLD;
			n.kind = cwr_pkg::KIND_POWER_ON;
			n.por_flag = 1'b0;
			n.from_wake = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s <= '{st: cwr_pkg::ST_HOLD, kind: cwr_pkg::KIND_POWER_ON, por_flag: 1'b0,
				cfg: cwr_pkg::CFG_ERASED, rdata: 16'h0000, wdt_rst: 1'b0, wake: 1'b0,
				erase: 1'b0, ext_prev: 1'b0, from_wake: 1'b0, pin_din: 1'b0};
		end else begin
			s <= n;
		end
	end

	assign chip_reset_n = !(s.st == cwr_pkg::ST_HOLD || s.st == cwr_pkg::ST_POWER_UP
		|| (s.st == cwr_pkg::ST_OSC_START && !s.from_wake) || ext_active || s.wdt_rst);
	assign core_run = chip_reset_n && s.st == cwr_pkg::ST_RUN;
	assign reset_kind = s.kind;
	assign power_on_flag = s.por_flag;
	assign wake_pulse = s.wake;
	assign sleeping = s.st == cwr_pkg::ST_SLEEP;
	assign prog_rdata = s.rdata;
	assign erase_pulse = s.erase;
	assign osc_mode = s.cfg[cwr_pkg::OSC_SEL_HI:cwr_pkg::OSC_SEL_LO];
	assign clkout_en = osc_mode == cwr_pkg::RC_CLOCKOUT_MODE
		|| osc_mode == cwr_pkg::INTERNAL_OSC_CLOCKOUT_MODE;
	assign osc_pins_crystal = crystal;
	assign int_osc_8mhz = s.cfg[cwr_pkg::FREQ_SEL_BIT];
	assign code_protect_en = !s.cfg[cwr_pkg::CODE_PROTECT_BIT];
	assign watchdog_en = s.cfg[cwr_pkg::WATCHDOG_EN_BIT];
	assign brown_out_en = brown_out_on(s.cfg[cwr_pkg::BROWN_OUT_SEL_HI:cwr_pkg::BROWN_OUT_SEL_LO], sleeping);
	assign pin_pullup_en = s.cfg[cwr_pkg::PIN_FN_BIT];
	assign pin_digital_in = s.pin_din;
	assign int_osc_stop = ext_active && s.cfg[cwr_pkg::OSC_SEL_HI];

	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence cp_off_write_s;
		cfg_hit && prog_wr && !s.cfg[cwr_pkg::CODE_PROTECT_BIT] && prog_wdata[cwr_pkg::CODE_PROTECT_BIT];
	endsequence
	sequence power_up_end_s;
		s.st == cwr_pkg::ST_POWER_UP && pu_done && vdd_ok && !bor_act;
	endsequence
	sequence wdt_wake_s;
		s.st == cwr_pkg::ST_SLEEP && wdt_timeout && vdd_ok && !bor_act && !ext_active;
	endsequence

	power_up_hold_a: assert property (s.st == cwr_pkg::ST_POWER_UP |-> !chip_reset_n)
		else $error("Reset released during power-up delay");
	power_up_entry_a: assert property ($rose(s.st == cwr_pkg::ST_POWER_UP) |-> $past(s.st) == cwr_pkg::ST_HOLD)
		else $error("Power-up delay entered from a non-hold state");
	power_up_bit_a: assert property (s.st == cwr_pkg::ST_POWER_UP |-> !s.cfg[cwr_pkg::POWER_UP_DIS_BIT])
		else $error("Power-up delay ran while disabled");
	osc_after_pu_a: assert property (power_up_end_s ##0 crystal |=> s.st == cwr_pkg::ST_OSC_START)
		else $error("Oscillator start delay did not follow power-up delay");
	osc_hold_a: assert property ((s.st == cwr_pkg::ST_OSC_START && !s.from_wake) |-> !chip_reset_n)
		else $error("Reset released before oscillator stable");
	erase_on_cp_a: assert property (cp_off_write_s |=> erase_pulse ##1 !erase_pulse)
		else $error("No single erase pulse when protection turned off");
	brown_out_sel_a: assert property ((s.cfg[9:8] == 2'h2 && sleeping) |-> !brown_out_en)
		else $error("Brown-out enabled in sleep with run-only select");
	pin_fn_off_a: assert property ((!s.cfg[cwr_pkg::PIN_FN_BIT] && s.st == cwr_pkg::ST_RUN && !s.wdt_rst)
		|-> chip_reset_n && !pin_pullup_en)
		else $error("Reset pin acted while configured as digital input");
	osc_stop_a: assert property ((ext_active && osc_mode inside {cwr_pkg::INTERNAL_OSC_IO_MODE,
		cwr_pkg::INTERNAL_OSC_CLOCKOUT_MODE, cwr_pkg::RC_OSC_IO_MODE, cwr_pkg::RC_CLOCKOUT_MODE}) |-> int_osc_stop)
		else $error("Internal oscillator not stopped during external reset");
	osc_run_a: assert property (!ext_active |-> !int_osc_stop)
		else $error("Internal oscillator stopped without external reset");
	wdt_wake_a: assert property (wdt_wake_s |=> wake_pulse && reset_kind == cwr_pkg::KIND_WATCHDOG_SLEEP
		&& chip_reset_n ##1 !wake_pulse)
		else $error("Watchdog wake-up caused a reset");
	wdt_run_a: assert property ((s.st == cwr_pkg::ST_RUN && wdt_timeout && vdd_ok && !bor_act)
		|=> !chip_reset_n && reset_kind == cwr_pkg::KIND_WATCHDOG_RUN ##1 s.st == cwr_pkg::ST_RUN)
		else $error("Watchdog reset not recorded or not pulsed");
	por_flag_a: assert property (!vdd_ok |=> !power_on_flag && s.st == cwr_pkg::ST_HOLD)
		else $error("Power-on flag not cleared by power-on");
	por_keep_a: assert property ((wdt_timeout && vdd_ok && !por_flag_set) |=> power_on_flag == $past(power_on_flag))
		else $error("Power-on flag changed by another reset");
	ext_comb_a: assert property (ext_active |-> !chip_reset_n && !core_run)
		else $error("External reset did not hold internal reset");
	cfg_ones_a: assert property ((s.cfg & cwr_pkg::CFG_UNIMPL_MASK) == cwr_pkg::CFG_UNIMPL_MASK)
		else $error("Unimplemented config bits not held at one");
	cfg_read_a: assert property ((cfg_hit && prog_rd) |=> prog_rdata == $past(s.cfg))
		else $error("Config read returned the wrong word");
	pu_skip_a: assert property ((s.st == cwr_pkg::ST_HOLD && s.cfg[cwr_pkg::POWER_UP_DIS_BIT])
		|=> s.st != cwr_pkg::ST_POWER_UP)
		else $error("Power-up delay ran although disabled");
	bor_restart_a: assert property ((s.st inside {cwr_pkg::ST_POWER_UP, cwr_pkg::ST_OSC_START} && bor_act && vdd_ok)
		|=> s.st == cwr_pkg::ST_HOLD && reset_kind == cwr_pkg::KIND_BROWN_OUT)
		else $error("Brown-out during a start-up delay did not restart it");
	pin_din_a: assert property (s.cfg[cwr_pkg::PIN_FN_BIT] |=> !pin_digital_in)
		else $error("Pin read as digital input while it is the reset pin");
	int_wake_a: assert property ((s.st == cwr_pkg::ST_SLEEP && int_wake && !wdt_timeout && vdd_ok && !bor_act
		&& !ext_active) |=> wake_pulse && $stable(reset_kind))
		else $error("Interrupt wake-up did not resume cleanly");
endmodule
`default_nettype wire

// ---- verilog/cwr_timeout_counter.sv ----
// Start-up delay counter that counts ticks while enabled
`default_nettype none
module cwr_timeout_counter #(
	parameter int unsigned LIMIT = 1024
) (
	input wire logic ref_clk, // System clock
	input wire logic rst_n, // Synchronous reset
	input wire logic run, // Count while high, clear when low
	input wire logic tick, // One count per high cycle
	output logic done // Limit reached
);
	localparam int W = $clog2(LIMIT + 1);
	localparam logic [W-1:0] LIM = W'(LIMIT);
	typedef struct packed {
		logic [W-1:0] cnt;
	} cwr_cnt_t;
	cwr_cnt_t s, n;
	always_comb begin
		n = s;
		if (!run)
			n.cnt = '0;
		else if (tick && s.cnt != LIM)
			n.cnt = s.cnt + W'(1);
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			s <= '0;
		else
			s <= n;
	end
	assign done = run && (s.cnt == LIM);
endmodule
`default_nettype wire
